/* rtl/charger_i2c_slave.sv */
// two-wire slave port with status and fault registers of the charger
`timescale 1ns/1ps
module charger_i2c_slave #(
  parameter int unsigned HANG_TIMEOUT_CYCLES = charger_pkg::HANG_TIMEOUT_CYC
) (
  // system clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // serial link, clock from the master
  input  wire logic                      scl,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  // charger status levels
  input  wire charger_pkg::status_pins_t status,
  // control outputs
  output logic                           storage_low_power_request,
  output logic                     [3:0] fault_mask
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta;    // first release stage
  logic rst_sync_n;  // released copy used everywhere

  // assert at once, release after two clock edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // link domain: bit engine on the master's clock
  // ---------------------------------------------------------------
  logic                       eng_run;    // engine reset from system side, low holds
  charger_pkg::engine_state_t state;      // byte role
  logic                 [3:0] bitcnt;     // bit index within the 9-bit slot
  logic                 [7:0] shift;      // received bits
  logic                       ack_pend;   // drive acknowledge in next slot
  logic                 [7:0] ptr;        // register pointer, kept across frames
  logic                 [7:0] wr_addr;    // held write target
  logic                 [7:0] wr_data;    // held write value
  logic                       wr_tog;     // toggles per write
  logic                       req_tog;    // toggles when a new byte must be fetched
  logic                       take_tog;   // toggles when a byte is loaded to send
  logic                 [7:0] tx;         // byte being sent
  logic                 [7:0] pref_data;  // fetched byte from the system side

  wire logic [7:0] rx_byte  = {shift[6:0], sda_in};
  wire logic       byte_end = (bitcnt == charger_pkg::LAST_BIT);
  wire logic       ack_slot = (bitcnt == charger_pkg::ACK_BIT);
  wire logic       addr_hit = (rx_byte[7:1] == charger_pkg::SLAVE_ADDR);
  wire logic       load_now = (state == charger_pkg::ST_RDATA) && (bitcnt == 4'h0);

  // sample on rising clock; rate-agnostic, so both speeds work alike
  always_ff @(posedge scl or negedge eng_run) begin
    if (!eng_run) begin
      state    <= charger_pkg::ST_ADDR;
      bitcnt   <= 4'h0;
      shift    <= 8'h00;
      ack_pend <= 1'b0;
    end else if (ack_slot) begin
      // ninth bit: restart the byte; a master nack ends a read
      bitcnt   <= 4'h0;
      ack_pend <= 1'b0;
      if (state == charger_pkg::ST_RDATA && sda_in) begin
        state <= charger_pkg::ST_IDLE;
      end
    end else begin
      bitcnt <= bitcnt + 4'h1;
      shift  <= rx_byte;
      if (byte_end) begin
        case (state)
          charger_pkg::ST_ADDR: begin
            // match 7-bit address, then split on direction bit
            ack_pend <= addr_hit;
            if (!addr_hit) begin
              state <= charger_pkg::ST_IDLE;
            end else if (rx_byte[0]) begin
              state <= charger_pkg::ST_RDATA;
            end else begin
              state <= charger_pkg::ST_REGSEL;
            end
          end
          charger_pkg::ST_REGSEL: begin
            ack_pend <= 1'b1;
            state    <= charger_pkg::ST_WDATA;
          end
          charger_pkg::ST_WDATA: begin
            ack_pend <= 1'b1;
          end
          default: begin
            ack_pend <= 1'b0;
          end
        endcase
      end
    end
  end

  // pointer and handoff toggles survive restarts so a read follows a selector
  always_ff @(posedge scl or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ptr     <= 8'h00;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      wr_tog  <= 1'b0;
      req_tog <= 1'b0;
    end else if (eng_run && !ack_slot && byte_end && state == charger_pkg::ST_REGSEL) begin
      // first byte after the address picks the register
      ptr     <= rx_byte;
      req_tog <= ~req_tog;
    end else if (eng_run && !ack_slot && byte_end && state == charger_pkg::ST_WDATA) begin
      // later bytes write and step the pointer
      wr_addr <= ptr;
      wr_data <= rx_byte;
      wr_tog  <= ~wr_tog;
      ptr     <= ptr + 8'h01;
      req_tog <= ~req_tog;
    end else if (eng_run && load_now) begin
      // step after loading so the next byte has eight bit times to arrive
      ptr     <= ptr + 8'h01;
      req_tog <= ~req_tog;
    end
  end

  // drive on falling clock so data is stable through the high phase
  always_ff @(negedge scl or negedge eng_run) begin
    if (!eng_run) begin
      sda_oe <= 1'b0;
      tx     <= 8'h00;
    end else if (ack_slot) begin
      sda_oe <= ack_pend;  // hold low the whole ninth high phase
    end else if (load_now) begin
      tx     <= {pref_data[6:0], 1'b0};
      sda_oe <= ~pref_data[7];
    end else if (state == charger_pkg::ST_RDATA) begin
      tx     <= {tx[6:0], 1'b0};
      sda_oe <= ~tx[7];
    end else begin
      sda_oe <= 1'b0;
    end
  end

  // tells the system side which byte went out, for clear-on-read
  always_ff @(negedge scl or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      take_tog <= 1'b0;
    end else if (eng_run && load_now) begin
      take_tog <= ~take_tog;
    end
  end

  // open drain: only ever pull low
  assign sda_out = 1'b0;

  // ---------------------------------------------------------------
  // system domain: synchronisers
  // ---------------------------------------------------------------
  logic                       scl_s;   // synchronised clock line
  logic                       sda_s;   // synchronised data line
  logic                       sda_d;   // previous data level
  logic                       sda_dd;  // data level two samples back
  logic                       scl_d;   // previous clock level
  charger_pkg::status_pins_t  st;      // synchronised status
  logic                 [2:0] tog_s;   // synchronised {wr, req, take}
  logic                 [2:0] tog_d;   // previous toggle levels

  level_sync #(.W(2), .INIT(2'h3)) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .d     ({scl, sda_in}),
    .q     ({scl_s, sda_s})
  );

  // switcher bit 4 starts at one so register 0x00 reads xx0x xxx1 after reset
  level_sync #(.W(11), .INIT(charger_pkg::STATUS_RESET)) u_status_sync (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .d     (status),
    .q     (st)
  );

  // toggles carry events; the words they announce are stable long before
  level_sync #(.W(3), .INIT(3'h0)) u_tog_sync (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .d     ({wr_tog, req_tog, take_tog}),
    .q     (tog_s)
  );

  // ---------------------------------------------------------------
  // system domain: frame tracking and bus-hang timeout
  // ---------------------------------------------------------------
  logic        in_frame;  // between start and stop
  logic  [1:0] hold_cnt;  // engine reset width after a start
  logic [31:0] hang_cnt;  // cycles of data held low

  // data must move between two high clock samples, so our own release never looks like a stop
  wire logic start_seen = scl_s && scl_d && sda_dd && !sda_d;
  wire logic stop_seen  = scl_s && scl_d && !sda_dd && sda_d;
  wire logic hang_hit   = in_frame && (hang_cnt >= HANG_TIMEOUT_CYCLES);
  wire logic wr_ev      = tog_s[2] ^ tog_d[2];
  wire logic req_ev     = tog_s[1] ^ tog_d[1];
  wire logic take_ev    = tog_s[0] ^ tog_d[0];

  // edge history for conditions and toggles
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sda_d  <= 1'b1;
      sda_dd <= 1'b1;
      scl_d  <= 1'b1;
      tog_d  <= 3'h0;
    end else begin
      sda_d  <= sda_s;
      sda_dd <= sda_d;
      scl_d  <= scl_s;
      tog_d  <= tog_s;
    end
  end

  // start pulses the engine reset; stop or hang keeps it held
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      in_frame <= 1'b0;
      eng_run  <= 1'b0;
      hold_cnt <= 2'h0;
    end else if (start_seen) begin
      in_frame <= 1'b1;
      eng_run  <= 1'b0;
      hold_cnt <= charger_pkg::START_HOLD_CYC;
    end else if (stop_seen || hang_hit) begin
      // release the line and ignore everything until the next start
      in_frame <= 1'b0;
      eng_run  <= 1'b0;
      hold_cnt <= 2'h0;
    end else if (hold_cnt != 2'h0) begin
      hold_cnt <= hold_cnt - 2'h1;
      eng_run  <= (hold_cnt == 2'h1);
    end
  end

  // counts only inside a frame while data is low; a start restarts it
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hang_cnt <= 32'h0;
    end else if (start_seen || !in_frame || sda_s) begin
      hang_cnt <= 32'h0;
    end else if (!hang_hit) begin
      hang_cnt <= hang_cnt + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // system domain: event flags
  // ---------------------------------------------------------------
  logic                      reset_flag;  // push-button reset seen
  logic                      timer_flag;  // safety timer fault held
  logic                      uv_flag;     // undervoltage event pending report
  logic                      oc_flag;     // overcurrent event pending report
  charger_pkg::status_pins_t st_d;        // previous status for edges
  logic                [7:0] pref_addr;   // register the fetched byte came from
  logic                      storage;     // storage-mode request bit
  logic                [3:0] mask;        // fault mask bits

  wire logic take0 = take_ev && (pref_addr == charger_pkg::REG_STATUS);
  wire logic take1 = take_ev && (pref_addr == charger_pkg::REG_FAULT);
  wire logic clr_reset = take0 && pref_data[charger_pkg::BIT_RESET_FLT];
  wire logic clr_uv    = take1 && pref_data[charger_pkg::BIT_UNDERVOLT];
  wire logic clr_oc    = take1 && pref_data[charger_pkg::BIT_OVERCURR];
  wire logic set_reset = st.reset_condition && !st_d.reset_condition;
  wire logic set_uv    = st.input_undervolt && !st_d.input_undervolt;
  wire logic set_oc    = st.battery_overcurrent && !st_d.battery_overcurrent;
  wire logic set_timer = st.safety_timer_fault;
  wire logic cd_toggle = st.disable_pin_level ^ st_d.disable_pin_level;

  // a read clears only a flag that went out as one, the timer flag clears on a disable-pin move; a new event wins over the clear
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_d       <= charger_pkg::STATUS_RESET;
      reset_flag <= 1'b0;
      timer_flag <= 1'b0;
      uv_flag    <= 1'b0;
      oc_flag    <= 1'b0;
    end else begin
      st_d       <= st;
      reset_flag <= (reset_flag && !clr_reset) || set_reset;
      timer_flag <= (timer_flag && !cd_toggle) || set_timer;
      uv_flag    <= (uv_flag && !clr_uv) || set_uv;
      oc_flag    <= (oc_flag && !clr_oc) || set_oc;
    end
  end

  // ---------------------------------------------------------------
  // system domain: register write and read decode
  // ---------------------------------------------------------------
  // write-only bit reads as zero; flags and live levels per field
  wire logic [7:0] status_byte = {st.charge_state, 1'b0, reset_flag, timer_flag,
                                  st.input_dpm_active, st.disable_pin_level,
                                  st.switcher_output_enabled};
  // faults high, masks low
  wire logic [7:0] fault_byte  = {st.input_overvolt, uv_flag, st.battery_uvlo,
                                  oc_flag, mask};
  // anything off the map answers all ones
  wire logic [7:0] read_byte   = (ptr == charger_pkg::REG_STATUS) ? status_byte :
                                 (ptr == charger_pkg::REG_FAULT)  ? fault_byte  :
                                 charger_pkg::UNMAPPED_VALUE;

  // captured byte writes; pointer words are stable when their toggle lands
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      storage <= charger_pkg::STORAGE_RESET;
      mask    <= charger_pkg::MASK_RESET;
    end else if (wr_ev && wr_addr == charger_pkg::REG_STATUS) begin
      storage <= wr_data[charger_pkg::BIT_STORAGE];
    end else if (wr_ev && wr_addr == charger_pkg::REG_FAULT) begin
      mask    <= wr_data[3:0];
    end
  end

  // fetch ahead on each pointer move and on each start, so live bits are fresh
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pref_data <= charger_pkg::UNMAPPED_VALUE;
      pref_addr <= charger_pkg::UNMAPPED_VALUE;
    end else if (req_ev || start_seen) begin
      pref_data <= read_byte;
      pref_addr <= ptr;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign storage_low_power_request = storage;
  assign fault_mask                = mask;

endmodule

/* rtl/charger_pkg.sv */
// shared constants, field positions and carrier types of the charger serial slave
package charger_pkg;

  // ---------------------------------------------------------------
  // serial addressing
  // ---------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR     = 7'h6a;  // fixed 7-bit address
  localparam logic [7:0] REG_STATUS     = 8'h00;  // status and storage-mode control
  localparam logic [7:0] REG_FAULT      = 8'h01;  // fault flags and masks
  localparam logic [7:0] UNMAPPED_VALUE = 8'hff;  // read answer off the map

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_STORAGE    = 5;  // storage request, register 0x00
  localparam int BIT_RESET_FLT  = 4;  // push-button reset flag, register 0x00
  localparam int BIT_UNDERVOLT  = 6;  // input undervoltage flag, register 0x01
  localparam int BIT_OVERCURR   = 4;  // battery overcurrent flag, register 0x01

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic       STORAGE_RESET = 1'b0;    // normal operation
  localparam logic [3:0] MASK_RESET    = 4'h0;    // no fault masked
  localparam logic [10:0] STATUS_RESET = 11'h010; // switcher reads enabled

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ           = 100;    // system clock rate
  localparam int HANG_TIMEOUT_US   = 25000;  // data-low limit inside a frame
  localparam int HANG_TIMEOUT_CYC  = HANG_TIMEOUT_US * CLK_MHZ;
  localparam logic [1:0] START_HOLD_CYC = 2'h3;  // engine reset width after start
  localparam logic [3:0] LAST_BIT  = 4'h7;   // eighth data bit index
  localparam logic [3:0] ACK_BIT   = 4'h8;   // acknowledge slot index

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] charge_state;        // 00 ready, 01 charging, 10 done, 11 fault
    logic       reset_condition;     // push-button reset conditions met
    logic       safety_timer_fault;  // safety timer expired
    logic       input_dpm_active;    // input dynamic power management active
    logic       disable_pin_level;   // chip-disable pin level
    logic       switcher_output_enabled;
    logic       input_overvolt;      // live input overvoltage
    logic       input_undervolt;     // undervoltage event level
    logic       battery_uvlo;        // live battery undervoltage lockout
    logic       battery_overcurrent; // overcurrent event level
  } status_pins_t;

  typedef enum logic [2:0] {
    ST_ADDR,
    ST_REGSEL,
    ST_WDATA,
    ST_RDATA,
    ST_IDLE
  } engine_state_t;

endpackage

/* rtl/level_sync.sv */
// two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
module level_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ---------------------------------------------------------------
  // synchroniser stages
  // ---------------------------------------------------------------
  logic [W-1:0] meta;  // first stage, read only by the second

  // one chain per bit; each bit settles on its own
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta[i] <= INIT[i];
          q[i]    <= INIT[i];
        end else begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate

endmodule

/* testbench/charger_i2c_slave_properties.sv */
// concurrent checks on the ports of the charger serial slave
`timescale 1ns/1ps
module charger_i2c_slave_properties #(
  parameter int unsigned HANG_TIMEOUT_CYCLES = charger_pkg::HANG_TIMEOUT_CYC
) (
  // system clock and reset
  input wire logic                      clk,
  input wire logic                      rst_n,
  // serial link
  input wire logic                      scl,
  input wire logic                      sda_in,
  input wire logic                      sda_out,
  input wire logic                      sda_oe,
  // status and control
  input wire charger_pkg::status_pins_t status,
  input wire logic                      storage_low_power_request,
  input wire logic [3:0]                fault_mask
);
  // ---------------------------------------------------------------
  // span counters
  // ---------------------------------------------------------------
  logic [31:0] low_cnt;   // cycles the data line has stayed low
  logic [7:0]  high_cnt;  // cycles the clock line has stayed high, saturating

  // counters are plain helpers, so the long hang limit needs no repetition
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt  <= '0;
      high_cnt <= '0;
    end else begin
      low_cnt  <= sda_in ? 32'h0 : low_cnt + 32'h1;
      high_cnt <= scl ? high_cnt + {7'h0, high_cnt != 8'hff} : 8'h0;
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // stop: data rises while the clock stays high
  sequence s_stop;
    scl && !sda_in ##1 scl && sda_in;
  endsequence
  // device pulls data with the clock high
  sequence s_pull_high;
    scl && sda_oe;
  endsequence

  property p_reset_vals;
    $rose(rst_n) |-> fault_mask == 4'h0 && !storage_low_power_request;
  endproperty
  property p_oe_rise;
    $rose(sda_oe) |-> !scl;
  endproperty
  property p_oe_fall;
    $fell(sda_oe) |-> !scl;
  endproperty
  property p_pull_hold;
    s_pull_high |=> sda_oe || !scl;
  endproperty
  property p_stop_release;
    s_stop |-> ##[0:4] !sda_oe;
  endproperty
  property p_idle_quiet;
    high_cnt > 8'h0c |-> !sda_oe;
  endproperty
  property p_hang;
    low_cnt == HANG_TIMEOUT_CYCLES + 12 |-> !sda_oe;
  endproperty
  property p_open_drain;
    sda_out == 1'b0;
  endproperty
  property p_ctrl_idle;
    high_cnt > 8'h0c |=> $stable(fault_mask) && $stable(storage_low_power_request);
  endproperty

  a_reset_vals: assert property (p_reset_vals) else $error("control outputs not at reset values");
  a_oe_rise: assert property (p_oe_rise) else $error("data pull began with clock high");
  a_oe_fall: assert property (p_oe_fall) else $error("data pull ended with clock high");
  a_pull_hold: assert property (p_pull_hold) else $error("pull dropped inside clock high");
  a_stop_release: assert property (p_stop_release) else $error("data held after stop");
  a_idle_quiet: assert property (p_idle_quiet) else $error("data pulled while link idle");
  a_hang: assert property (p_hang) else $error("data still pulled after hang limit");
  a_open_drain: assert property (p_open_drain) else $error("data output not open drain");
  a_ctrl_idle: assert property (p_ctrl_idle) else $error("control changed while idle");
endmodule

bind charger_i2c_slave charger_i2c_slave_properties #(
  .HANG_TIMEOUT_CYCLES(HANG_TIMEOUT_CYCLES)
) i_props (
  .clk                       (clk),
  .rst_n                     (rst_n),
  .scl                       (scl),
  .sda_in                    (sda_in),
  .sda_out                   (sda_out),
  .sda_oe                    (sda_oe),
  .status                    (status),
  .storage_low_power_request (storage_low_power_request),
  .fault_mask                (fault_mask)
);

/* testbench/charger_i2c_slave_tb.sv */
// self-checking bench of the charger serial slave
`timescale 1ns/1ps
module charger_i2c_slave_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int unsigned HANG = 200;  // shortened hang limit keeps the run brief
  logic                      clk;
  logic                      rst_n;
  logic                      scl;
  logic                      sda_low;     // master pulls data low
  logic                      sda;         // resolved data wire
  logic                      sda_out;
  logic                      sda_oe;
  logic                      store_req;
  logic [3:0]                fault_mask;
  charger_pkg::status_pins_t st;
  logic [7:0]                q;
  logic                      a;
  logic [7:0]                ad;
  int                        n_mismatch = 0;
  int                        n_checks = 0;

  // pull-up wins unless either party pulls low
  assign sda = ~(sda_oe | sda_low);

  charger_i2c_slave #(.HANG_TIMEOUT_CYCLES(HANG)) i_dut (
    .clk                       (clk),
    .rst_n                     (rst_n),
    .scl                       (scl),
    .sda_in                    (sda),
    .sda_out                   (sda_out),
    .sda_oe                    (sda_oe),
    .status                    (st),
    .storage_low_power_request (store_req),
    .fault_mask                (fault_mask)
  );
  i2c_master_model i_master (.scl(scl), .sda_low(sda_low), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // levels pass a two-flop synchroniser, so give them time
  task automatic settle();
    repeat (8) @(negedge clk);
  endtask
  task automatic byte_out(input logic [7:0] d);
    i_master.xfer(d, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
  endtask
  task automatic wr_reg(input logic [7:0] r, input logic [7:0] d);
    i_master.start();
    byte_out(8'hd4);
    byte_out(r);
    byte_out(d);
    i_master.stop();
  endtask
  // selector write, repeated start, one byte read with a final nack
  task automatic rd_chk(input logic [7:0] r, input logic [7:0] exp);
    i_master.start();
    byte_out(8'hd4);
    byte_out(r);
    i_master.start();
    byte_out(8'hd5);
    i_master.xfer(8'hff, 1'b1, q, a);
    i_master.stop();
    chk(q, exp);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial begin
    #600us;
    n_mismatch++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    st = '0;
    st.switcher_output_enabled = 1'b1;
    ad = 8'hd4;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    settle();  // rail up before the first frame
    rd_chk(charger_pkg::REG_STATUS, 8'h01);
    @(negedge clk) st.input_dpm_active = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk) st.charge_state = i[1:0];
      settle();
      rd_chk(charger_pkg::REG_STATUS, {i[1:0], 6'h05});
    end
    // storage request is write-only and reads back zero
    wr_reg(charger_pkg::REG_STATUS, 8'h20);
    chk({7'h0, store_req}, 8'h01);
    rd_chk(charger_pkg::REG_STATUS, 8'hc5);
    wr_reg(charger_pkg::REG_STATUS, 8'h00);
    chk({7'h0, store_req}, 8'h00);
    // push-button flag shows once
    @(negedge clk) st.reset_condition = 1'b1;
    settle();
    @(negedge clk) st.reset_condition = 1'b0;
    settle();
    rd_chk(charger_pkg::REG_STATUS, 8'hd5);
    rd_chk(charger_pkg::REG_STATUS, 8'hc5);
    // timer flag survives reads until the disable pin moves
    @(negedge clk) st.safety_timer_fault = 1'b1;
    settle();
    @(negedge clk) st.safety_timer_fault = 1'b0;
    settle();
    rd_chk(charger_pkg::REG_STATUS, 8'hcd);
    rd_chk(charger_pkg::REG_STATUS, 8'hcd);
    @(negedge clk) st.disable_pin_level = 1'b1;
    settle();
    rd_chk(charger_pkg::REG_STATUS, 8'hc7);
    // fault flags and masks
    wr_reg(charger_pkg::REG_FAULT, 8'h0a);
    chk({4'h0, fault_mask}, 8'h0a);
    @(negedge clk) st.input_overvolt = 1'b1;
    st.input_undervolt = 1'b1;
    st.battery_uvlo = 1'b1;
    st.battery_overcurrent = 1'b1;
    settle();
    rd_chk(charger_pkg::REG_FAULT, 8'hfa);
    rd_chk(charger_pkg::REG_FAULT, 8'haa);
    rd_chk(8'h02, charger_pkg::UNMAPPED_VALUE);
    rd_chk(8'hff, charger_pkg::UNMAPPED_VALUE);
    // a write off the map leaves every control bit alone
    wr_reg(8'h02, 8'h3f);
    chk({3'h0, store_req, fault_mask}, 8'h0a);
    // foreign address gets no acknowledge
    i_master.start();
    i_master.xfer(8'hd6, 1'b1, q, a);
    chk({7'h0, a}, 8'h01);
    i_master.stop();
    // master stalls during the acknowledge: engine must let go
    i_master.start();
    for (int i = 7; i >= 0; i--) i_master.bit_io(ad[i], a);
    repeat (2) @(negedge clk);
    chk({7'h0, sda_oe}, 8'h01);
    repeat (HANG + 40) @(negedge clk);
    chk({7'h0, sda_oe}, 8'h00);
    i_master.stop();  // stop after the aborted frame
    rd_chk(charger_pkg::REG_STATUS, 8'hc7);
    finish_test();
  end
endmodule

/* testbench/i2c_master_model.sv */
// bus master model: makes the serial clock and pulls the data line
`timescale 1ns/1ps
module i2c_master_model (
  // serial link
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // clock stands high between frames, data released to the pull-up
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // start, or repeated start when the clock is low
  task automatic start();
    if (!scl) begin
      #20 sda_low = 1'b0;
      #20 scl = 1'b1;
      #40;
    end
    sda_low = 1'b1;  // data falls with clock high
    #100 scl = 1'b0;  // long hold lets the engine come out of reset
  endtask

  // one bit: data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    #20 sda_low = ~b;
    #20 scl = 1'b1;
    r = sda;  // sampled at the rising edge
    #40 scl = 1'b0;
  endtask

  // eight bits msb first, then the receiver's acknowledge
  task automatic xfer(input logic [7:0] d, input logic mack,
                      output logic [7:0] q, output logic sack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(mack, sack);
  endtask

  // stop: data rises with clock high, then clock stands still
  task automatic stop();
    #20 sda_low = 1'b1;
    #20 scl = 1'b1;
    #40 sda_low = 1'b0;
    #40;
  endtask
endmodule
